//--- pmbs_top.sv
// Loop mode control, lock reporting and glitch-free base clock select.
// Assumes an APB master on pclk; source clocks and detector levels are
// asynchronous pins and must be much slower than pclk.
//
// Functional notes
// - Auto mode: tracking-select is read-only mode status.
// - Auto: tracking set within tracking tolerance, cleared outside untrack.
// - Auto: read-only lock, set within lock, cleared outside unlock.
// - Auto: lock toggle with interrupt enable raises interrupt.
// - Manual: tracking-select writable, 0 acquisition, 1 tracking.
// - Manual: lock disabled, no interrupts.
// - Oscillator is N times reference; bus is quarter of source.
// - Program register: N in upper four bits, L lower.
// - N of zero acts as one.
// - L of zero disables loop and forces crystal source.
// - Source change holds output while counting three edges each.
// - Selected source divided by two for the base clock.
// - Select bit: 0 crystal, 1 oscillator.
// - Oscillator select refused while loop is off.
// - Loop stays on while oscillator is selected.
// - One write never changes power and selection together.
// - Oscillator and loop run only with oscillator enable.
// - Tracking-select reads 0 acquiring, 1 tracking.
// - Program register read-only while loop is on.
// - Reading control register clears lock-change flag.
//
// The implementer's own choices: the APB register port and the register addresses.

`timescale 1ns/1ps

module pmbs_top
    import pmbs_pkg::*;
(
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        xtal_clk,
    input  wire logic        vco_clk,
    input  wire logic        osc_enable_in,
    input  wire logic        vco_in_trk_tol,
    input  wire logic        vco_out_untrk_tol,
    input  wire logic        vco_in_lock_tol,
    input  wire logic        vco_out_unlock_tol,
    output logic             xtal_clk_out,
    output logic             base_clk_out,
    output logic             clkgen_irq,
    output logic             osc_run,
    output logic             loop_enable,
    output logic             track_mode,
    output logic      [3:0]  mult_n_out,
    output logic      [3:0]  range_l_out
);

    // ----------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------
    function automatic logic rise(input logic [1:0] sy,
                                  input logic       d);
        rise = sy[1] & ~d;
    endfunction

    function automatic logic [3:0] eff_n(input logic [7:0] p);
        eff_n = (p[7:4] == PMBS_ZERO4) ? PMBS_N_ONE : p[7:4];
    endfunction

    pmbs_state_s q;
    pmbs_state_s n;

    logic done;
    logic wr;
    logic rd_ctrl;
    logic pw_new;
    logic xr;
    logic vr;

    // ----------------------------------------------------------------
    // Next state
    // ----------------------------------------------------------------
    always_comb begin
        n = q;
        n.xtal_sy     = {q.xtal_sy[0], xtal_clk};
        n.vco_sy      = {q.vco_sy[0], vco_clk};
        n.xtal_d      = q.xtal_sy[1];
        n.vco_d       = q.vco_sy[1];
        n.oscen_sy    = {q.oscen_sy[0], osc_enable_in};
        n.trk_in_sy   = {q.trk_in_sy[0], vco_in_trk_tol};
        n.trk_out_sy  = {q.trk_out_sy[0], vco_out_untrk_tol};
        n.lock_in_sy  = {q.lock_in_sy[0], vco_in_lock_tol};
        n.lock_out_sy = {q.lock_out_sy[0], vco_out_unlock_tol};
        xr = rise(q.xtal_sy, q.xtal_d);
        vr = rise(q.vco_sy, q.vco_d);

        // Bus: one wait state, so read data is ready when pready rises
        done    = psel & penable & q.pready;
        wr      = done & pwrite;
        rd_ctrl = done & ~pwrite & (paddr == PMBS_ADR_CTRL);
        n.pready  = psel & penable & ~q.pready;
        n.pslverr = 1'b0;
        n.prdata  = q.prdata;
        pw_new    = q.power_on;
        if (psel && penable && !q.pready) begin
            n.prdata = '0;
            unique case (paddr)
                PMBS_ADR_CTRL: n.prdata[7:0] = {q.irq_en & q.auto_bw,
                    q.flag & q.auto_bw, q.power_on, q.base_sel,
                    PMBS_CTRL_LOW};
                PMBS_ADR_BW: n.prdata[7:0] = {q.auto_bw,
                    q.lock & q.auto_bw, q.trk, q.xld, PMBS_BW_LOW};
                PMBS_ADR_PROG: n.prdata[7:0] = q.prog;
                default: n.pslverr = 1'b1;
            endcase
        end

        if (wr && paddr == PMBS_ADR_CTRL) begin
            n.irq_en = pwdata[PMBS_B_IRQ_EN];
            pw_new   = pwdata[PMBS_B_PWR] | q.base_sel;
            if (pw_new != q.power_on) begin
                n.power_on = pw_new;
            end else if (q.power_on) begin
                n.base_sel = pwdata[PMBS_B_SEL];
            end else begin
                n.base_sel = 1'b0;
            end
        end
        if (wr && paddr == PMBS_ADR_BW) begin
            n.auto_bw = pwdata[PMBS_B_AUTO];
            n.xld     = pwdata[PMBS_B_XLD];
            if (!q.auto_bw) begin
                n.trk = pwdata[PMBS_B_TRK];
            end
        end
        if (wr && paddr == PMBS_ADR_PROG && !q.power_on) begin
            n.prog = pwdata[7:0];
        end
        if (n.prog[3:0] == PMBS_ZERO4) begin
            n.base_sel = 1'b0;
        end

        // Detectors only act in automatic mode; off loop reads unlocked
        if (q.auto_bw) begin
            if (!q.loop_en) begin
                n.trk  = 1'b0;
                n.lock = 1'b0;
            end else begin
                if (q.trk_in_sy[1]) begin
                    n.trk = 1'b1;
                end else if (q.trk_out_sy[1]) begin
                    n.trk = 1'b0;
                end
                if (q.lock_in_sy[1]) begin
                    n.lock = 1'b1;
                end else if (q.lock_out_sy[1]) begin
                    n.lock = 1'b0;
                end
            end
        end
        if (!n.auto_bw) begin
            n.lock   = 1'b0;
            n.irq_en = 1'b0;
        end

        // A toggle in the clearing cycle still sets the flag
        if (rd_ctrl) begin
            n.flag = 1'b0;
        end
        if (n.auto_bw && n.lock != q.lock) begin
            n.flag = 1'b1;
        end
        if (!n.auto_bw) begin
            n.flag = 1'b0;
        end
        n.irq = n.flag & n.irq_en & n.auto_bw;

        n.osc_run  = q.oscen_sy[1];
        n.loop_en  = n.power_on & q.oscen_sy[1]
                   & (n.prog[3:0] != PMBS_ZERO4);
        n.mult_n   = eff_n(n.prog);
        n.xtal_out = q.xtal_sy[1];

        // Transition control; both sources must show three edges, so a
        // dead source stalls the switch with the output held.
        unique case (q.st)
            PMBS_ST_RUN: begin
                if (q.base_sel != q.active_src) begin
                    n.st   = PMBS_ST_SWITCH;
                    n.xcnt = 2'h0;
                    n.vcnt = 2'h0;
                end else if (q.active_src ? vr : xr) begin
                    n.base_clk = ~q.base_clk;
                end
            end
            PMBS_ST_SWITCH: begin
                if (xr && q.xcnt != PMBS_EDGES) begin
                    n.xcnt = q.xcnt + 2'h1;
                end
                if (vr && q.vcnt != PMBS_EDGES) begin
                    n.vcnt = q.vcnt + 2'h1;
                end
                if (n.xcnt == PMBS_EDGES && n.vcnt == PMBS_EDGES) begin
                    n.st         = PMBS_ST_RUN;
                    n.active_src = q.base_sel;
                end
            end
        endcase
    end

    // ----------------------------------------------------------------
    // State register
    // ----------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            q      <= '0;
            q.prog <= PMBS_RST_PROG;
            q.mult_n <= PMBS_N_ONE;
            q.st   <= PMBS_ST_RUN;
        end else begin
            q <= n;
        end
    end

    assign prdata       = q.prdata;
    assign pready       = q.pready;
    assign pslverr      = q.pslverr;
    assign xtal_clk_out = q.xtal_out;
    assign base_clk_out = q.base_clk;
    assign clkgen_irq   = q.irq;
    assign osc_run      = q.osc_run;
    assign loop_enable  = q.loop_en;
    assign track_mode   = q.trk;
    assign mult_n_out   = q.mult_n;
    assign range_l_out  = q.prog[3:0];

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    AST_TRK_RO: assert property (
        q.auto_bw && q.loop_en && !q.trk_in_sy[1] && !q.trk
        |=> !q.trk)
        else $error("tracking bit set without detector in auto mode");
    AST_TRK_SET: assert property (
        q.auto_bw && q.loop_en && q.trk_in_sy[1] |=> q.trk)
        else $error("tracking bit not set inside tolerance");
    AST_LOCK_SET: assert property (
        q.auto_bw && q.loop_en && q.lock_in_sy[1] |=> q.lock || !q.auto_bw)
        else $error("lock not set inside tolerance");
    AST_IRQ: assert property (
        $changed(q.lock) && q.auto_bw && q.irq_en |-> clkgen_irq)
        else $error("lock toggle did not raise interrupt");
    AST_MANUAL: assert property (
        !q.auto_bw |-> !clkgen_irq && !q.lock && !q.flag)
        else $error("manual mode shows lock or interrupt");
    AST_N_ZERO: assert property (
        q.prog[7:4] == 4'h0 |-> mult_n_out == 4'h1)
        else $error("zero multiplier not treated as one");
    AST_L_ZERO: assert property (
        q.prog[3:0] == 4'h0 |-> !q.base_sel && !loop_enable)
        else $error("zero range factor left loop usable");
    AST_HOLD: assert property (
        q.st == PMBS_ST_SWITCH |=> $stable(base_clk_out))
        else $error("base clock moved during source switch");
    AST_PWR: assert property (
        q.base_sel |-> q.power_on)
        else $error("loop off while oscillator selected");
    AST_ONE_CHANGE: assert property (
        $changed(q.power_on) |-> $stable(q.base_sel))
        else $error("power and selection changed together");
    AST_PROG_RO: assert property (
        q.power_on |=> $stable(q.prog))
        else $error("program register changed while loop on");
    AST_FLAG_CLR: assert property (
        psel && penable && pready && !pwrite && paddr == PMBS_ADR_CTRL
        && q.lock == n.lock |=> !q.flag)
        else $error("flag not cleared by control read");

endmodule

//--- pmbs_pkg.sv
// Constants and state types for the loop mode and base clock select block.
// Assumes an APB master with 12-bit byte addresses and 32-bit data.

package pmbs_pkg;

    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    // Printed offsets are not all word aligned, so they are indices
    localparam logic [9:0]  PMBS_IDX_CTRL = 10'h01C;
    localparam logic [9:0]  PMBS_IDX_BW   = 10'h01D;
    localparam logic [9:0]  PMBS_IDX_PROG = 10'h01E;
    localparam logic [11:0] PMBS_ADR_CTRL = {PMBS_IDX_CTRL, 2'b00};
    localparam logic [11:0] PMBS_ADR_BW   = {PMBS_IDX_BW, 2'b00};
    localparam logic [11:0] PMBS_ADR_PROG = {PMBS_IDX_PROG, 2'b00};

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int PMBS_B_IRQ_EN = 7;
    localparam int PMBS_B_FLAG   = 6;
    localparam int PMBS_B_PWR    = 5;
    localparam int PMBS_B_SEL    = 4;
    localparam int PMBS_B_AUTO   = 7;
    localparam int PMBS_B_LOCK   = 6;
    localparam int PMBS_B_TRK    = 5;
    localparam int PMBS_B_XLD    = 4;
    localparam logic [3:0] PMBS_CTRL_LOW = 4'hF;
    localparam logic [3:0] PMBS_BW_LOW   = 4'h0;

    // ----------------------------------------------------------------
    // Reset values and counts
    // ----------------------------------------------------------------
    localparam logic [7:0] PMBS_RST_PROG = 8'h11;
    localparam logic [3:0] PMBS_N_ONE    = 4'h1;
    localparam logic [3:0] PMBS_ZERO4    = 4'h0;
    localparam logic [1:0] PMBS_EDGES    = 2'h3;

    typedef enum logic [0:0] {
        PMBS_ST_RUN    = 1'b0,
        PMBS_ST_SWITCH = 1'b1
    } pmbs_state_e;

    typedef struct packed {
        logic [1:0]  xtal_sy;
        logic        xtal_d;
        logic [1:0]  vco_sy;
        logic        vco_d;
        logic [1:0]  oscen_sy;
        logic [1:0]  trk_in_sy;
        logic [1:0]  trk_out_sy;
        logic [1:0]  lock_in_sy;
        logic [1:0]  lock_out_sy;
        logic        irq_en;
        logic        flag;
        logic        power_on;
        logic        base_sel;
        logic        auto_bw;
        logic        lock;
        logic        trk;
        logic        xld;
        logic [7:0]  prog;
        pmbs_state_e st;
        logic        active_src;
        logic [1:0]  xcnt;
        logic [1:0]  vcnt;
        logic        base_clk;
        logic        irq;
        logic        loop_en;
        logic [3:0]  mult_n;
        logic        xtal_out;
        logic        osc_run;
        logic        pready;
        logic        pslverr;
        logic [31:0] prdata;
    } pmbs_state_s;

endpackage

//--- pmbs_sim_model.sv
// System integration side model: oscillator enable and base clock load.
// Assumes base_clk_out is a pclk-registered level from the design.
`timescale 1ns/1ps
module pmbs_sim_model (
    input  wire logic        pclk,
    input  wire logic        presetn,
    input  wire logic        osc_req,
    input  wire logic        base_clk_out,
    output logic             osc_enable_in,
    output logic             bus_clk,
    output logic      [15:0] base_toggles
);
    logic base_d;
    // Bus clock is half the base clock, so a quarter of the source
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            osc_enable_in <= 1'b0;
            base_d        <= 1'b0;
            bus_clk       <= 1'b0;
            base_toggles  <= 16'h0000;
        end else begin
            osc_enable_in <= osc_req;
            base_d        <= base_clk_out;
            if (base_d != base_clk_out) begin
                base_toggles <= base_toggles + 16'h0001;
            end
            if (base_clk_out && !base_d) begin
                bus_clk <= ~bus_clk;
            end
        end
    end
endmodule

//--- pll_mode_and_base_clock_select_tb.sv
// Self-checking bench: APB master, source clocks and detector levels.
// Assumes the pmbs_top port list and the register map of pmbs_pkg.
`timescale 1ns/1ps
module pll_mode_and_base_clock_select_tb;
    import pmbs_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, xtal_clk = 0, vco_clk = 0, osc_req = 0;
    logic trk_in = 0, untrk = 0, lk_in = 0, unlk = 0, osc_en, bus_clk;
    logic base_clk_out, clkgen_irq, osc_run, loop_enable, track_mode;
    logic [3:0] mult_n_out, range_l_out;
    logic [15:0] tog, t0;
    logic [7:0] p;
    logic rerr, xo;
    logic [2:0] xsh = 3'h0;
    int err_total = 0, n_compared = 0, i;
    always #12.5 pclk = ~pclk;
    always #100 xtal_clk = ~xtal_clk;
    initial #37 forever #150 vco_clk = ~vco_clk;
    // Crystal level three edges back, the resampled output's delay
    always @(posedge pclk) xsh <= {xsh[1:0], xtal_clk};
    pmbs_top pmbs_top_inst (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .xtal_clk(xtal_clk), .vco_clk(vco_clk), .osc_enable_in(osc_en),
        .vco_in_trk_tol(trk_in), .vco_out_untrk_tol(untrk),
        .vco_in_lock_tol(lk_in), .vco_out_unlock_tol(unlk),
        .xtal_clk_out(xo), .base_clk_out(base_clk_out),
        .clkgen_irq(clkgen_irq), .osc_run(osc_run),
        .loop_enable(loop_enable), .track_mode(track_mode),
        .mult_n_out(mult_n_out), .range_l_out(range_l_out));
    pmbs_sim_model pmbs_sim_model_inst (.pclk(pclk), .presetn(presetn),
        .osc_req(osc_req), .base_clk_out(base_clk_out),
        .osc_enable_in(osc_en), .bus_clk(bus_clk), .base_toggles(tog));
    function automatic logic [3:0] exp_n(input logic [3:0] n);
        return (n == 4'h0) ? 4'h1 : n;
    endfunction
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_compared++;
        if (g !== e) begin
            err_total++;
            $display("BAD t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask
    // Request held until the edge at which pready is seen high
    task automatic apb(input logic w, input logic [11:0] a,
                       input logic [31:0] d);
        int k;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // Outputs are read here before this edge's update lands
        for (k = 0; k < 20; k++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (k == 20) begin
            err_total++;
            end_sim();
        end
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic rdc(input logic [11:0] a, input logic [7:0] e);
        apb(1'b0, a, 32'h0);
        chk(rdat, {24'h0, e});
    endtask
    task automatic cyc(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic meas(input int per);
        t0 = tog;
        cyc(120);
        t0 = tog - t0;
        chk(32'(t0 >= 16'(3000 / per - 1) && t0 <= 16'(3000 / per + 1)), 1);
    endtask
    initial begin
        void'($urandom(32'hFBCDC329));
        osc_req <= 1'b1;
        cyc(6);
        presetn <= 1'b1;
        rdc(PMBS_ADR_CTRL, 8'h0F);
        rdc(PMBS_ADR_BW, 8'h00);
        rdc(PMBS_ADR_PROG, PMBS_RST_PROG);
        apb(1'b0, 12'hFFC, 32'h0);
        chk({31'h0, rerr}, 32'h1);
        chk(rdat, 32'h0);
        // Random program values, with N of zero forced in once
        for (i = 0; i < 8; i++) begin
            p = (i == 0) ? 8'h05 : 8'($urandom);
            apb(1'b1, PMBS_ADR_PROG, {24'h0, p});
            rdc(PMBS_ADR_PROG, p);
            chk({mult_n_out, range_l_out}, {exp_n(p[7:4]), p[3:0]});
        end
        apb(1'b1, PMBS_ADR_PROG, 32'h43);
        apb(1'b1, PMBS_ADR_CTRL, 32'h80);
        @(posedge pclk) lk_in <= 1'b1;
        cyc(5);
        rdc(PMBS_ADR_CTRL, 8'h0F);
        rdc(PMBS_ADR_BW, 8'h00);
        apb(1'b1, PMBS_ADR_BW, 32'h20);
        rdc(PMBS_ADR_BW, 8'h20);
        chk(track_mode, 1);
        apb(1'b1, PMBS_ADR_BW, 32'h00);
        cyc(1);
        chk({track_mode, clkgen_irq}, 0);
        apb(1'b1, PMBS_ADR_CTRL, 32'h10);
        rdc(PMBS_ADR_CTRL, 8'h0F);
        apb(1'b1, PMBS_ADR_CTRL, 32'h30);
        rdc(PMBS_ADR_CTRL, 8'h2F);
        apb(1'b1, PMBS_ADR_PROG, 32'h99);
        rdc(PMBS_ADR_PROG, 8'h43);
        @(posedge pclk) osc_req <= 1'b0;
        cyc(8);
        chk({loop_enable, osc_run}, 0);
        @(posedge pclk) osc_req <= 1'b1;
        cyc(8);
        chk({loop_enable, osc_run}, 3);
        meas(200);
        repeat (16) begin
            @(posedge pclk);
            chk(xo, xsh[2]);
        end
        cyc(40);
        apb(1'b1, PMBS_ADR_BW, 32'h20);
        cyc(40);
        apb(1'b1, PMBS_ADR_CTRL, 32'h30);
        cyc(2);
        t0 = tog;
        cyc(10);
        chk(tog, t0);
        cyc(80);
        meas(300);
        apb(1'b1, PMBS_ADR_CTRL, 32'h10);
        rdc(PMBS_ADR_CTRL, 8'h3F);
        apb(1'b1, PMBS_ADR_CTRL, 32'h00);
        apb(1'b1, PMBS_ADR_CTRL, 32'h00);
        apb(1'b1, PMBS_ADR_BW, 32'h80);
        apb(1'b1, PMBS_ADR_CTRL, 32'hA0);
        cyc(8);
        chk(clkgen_irq, 1);
        rdc(PMBS_ADR_BW, 8'hC0);
        apb(1'b1, PMBS_ADR_BW, 32'hA0);
        rdc(PMBS_ADR_BW, 8'hC0);
        @(posedge pclk) trk_in <= 1'b1;
        cyc(5);
        rdc(PMBS_ADR_BW, 8'hE0);
        @(posedge pclk) {trk_in, untrk} <= 2'b01;
        cyc(5);
        rdc(PMBS_ADR_BW, 8'hC0);
        rdc(PMBS_ADR_CTRL, 8'hEF);
        rdc(PMBS_ADR_CTRL, 8'hAF);
        chk(clkgen_irq, 0);
        @(posedge pclk) {lk_in, unlk} <= 2'b01;
        cyc(5);
        rdc(PMBS_ADR_BW, 8'h80);
        chk(clkgen_irq, 1);
        apb(1'b1, PMBS_ADR_CTRL, 32'h00);
        apb(1'b1, PMBS_ADR_PROG, 32'h40);
        apb(1'b1, PMBS_ADR_CTRL, 32'h30);
        cyc(3);
        chk(loop_enable, 0);
        apb(1'b1, PMBS_ADR_CTRL, 32'h30);
        rdc(PMBS_ADR_CTRL, 8'h6F);
        end_sim();
    end
endmodule
